// file: src/lvl_pkg.sv
// constants, register map and gain table for the automatic level limiter
// assumes a 250 MHz mclk and a host register port behind a serial bridge
// What this block does
// - enable bit gates; mode field selects behaviour
// - peak watches signal after soft-mute compensation
// - bit 11 picks rectified or decaying peak
// - optional zero-cross deferral of gain changes
// - limiter zero-cross forces gain-stage zero-cross
// - enable loads maximum gain at once
// - gain stays between upper and lower limits
// - attack steps down, interval doubles per code
// - attack stops 1.5 dB below target
// - release steps up, interval doubles per code
// - gain rises only after full hold time
// - attack immediate; release only after hold
// - compare peak after every attack/release step
// - target is fraction of full scale
// - mode 000: clip starts attack immediately
// - per-event attenuation capped by clip field
// - clip modes floor attenuation at -32 dB
// - new clip event grants another attenuation cap
// - clip modes hold until quiet, then release
// - mode 001: clip and low battery
// - mode 010: peak above target triggers
package lvl_pkg;
    // register offsets
    localparam logic [7:0]  ADDR_GAIN_DETECT = 8'h2c;
    localparam logic [7:0]  ADDR_TIMING      = 8'h2d;
    localparam logic [7:0]  ADDR_ENABLE_MODE = 8'h2e;
    localparam logic [7:0]  ADDR_CLIP_STEP   = 8'h2f;
    localparam logic [7:0]  ADDR_CLIP_DET    = 8'h69;
    localparam logic [7:0]  ADDR_STATUS      = 8'h30;
    localparam logic [15:0] RST_REG          = 16'h0000;
    // field positions
    localparam int EN_BIT = 15, MODE_HI = 14, MODE_LO = 12, VBAT_HI = 9, VBAT_LO = 5;
    localparam int ZC_BIT = 14, PK_BIT = 11, UP_HI = 7, UP_LO = 5, LO_HI = 3, LO_LO = 1;
    localparam int REL_HI = 15, REL_LO = 12, ATK_HI = 11, ATK_LO = 8;
    localparam int HOLD_HI = 7, HOLD_LO = 4, TGT_HI = 3, TGT_LO = 1;
    localparam int GSZC_BIT = 14, CAP_HI = 12, CAP_LO = 10, CLIPDET_BIT = 4;
    // limiter modes
    localparam logic [2:0] MODE_CLIP        = 3'h0;
    localparam logic [2:0] MODE_LOWBAT_CLIP = 3'h1;
    localparam logic [2:0] MODE_NORMAL      = 3'h2;
    // timing, least times round up to whole cycles
    localparam int CLK_PERIOD_PS = 4000;
    localparam int ATK_BASE_NS   = 2000;
    localparam int REL_BASE_US   = 500;
    localparam int HOLD_BASE_MS  = 1;
    localparam int ATK_BASE_CYC  = (ATK_BASE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int REL_BASE_CYC  = (REL_BASE_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int HOLD_BASE_CYC = (HOLD_BASE_MS * 1000000000 + CLK_PERIOD_PS - 1)
                                   / CLK_PERIOD_PS;
    localparam logic [3:0] ATK_MAX_SHIFT  = 4'hb;
    localparam logic [3:0] REL_MAX_SHIFT  = 4'hb;
    localparam logic [3:0] HOLD_MAX_SHIFT = 4'h9;
    // attenuation in 0.1875 dB steps
    localparam logic [7:0] LO_ATTEN_BASE   = 8'h20;
    localparam logic [7:0] CLIP_ATTEN_FLOOR = 8'haa;
    localparam int         PEAK_DECAY_SH   = 6;
    // 2^(-k/32) in q1.15, one 6 dB octave of gain
    localparam logic [15:0] GAIN_TBL [32] = '{
        16'h8000, 16'h7d42, 16'h7a93, 16'h77f3, 16'h7560, 16'h72dd, 16'h7066, 16'h6dfe,
        16'h6ba2, 16'h6954, 16'h6712, 16'h64dd, 16'h62b4, 16'h6096, 16'h5e84, 16'h5c7e,
        16'h5a82, 16'h5892, 16'h56ac, 16'h54d1, 16'h52ff, 16'h5138, 16'h4f7a, 16'h4dc6,
        16'h4c1c, 16'h4a7a, 16'h48e2, 16'h4752, 16'h45cb, 16'h444c, 16'h42d5, 16'h4167};
    typedef enum logic [1:0] {st_idle, st_attack, st_hold, st_release} lvl_state_t;
endpackage

// file: src/lvl_limiter.sv
// level limiter: sample fifo, digital gain stage, peak detector, control fsm
// assumes samples after soft-mute compensation and a synchronous clip flag
`timescale 1ns/100ps

module lvl_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire logic             wr_valid,
    output logic                  wr_ready,
    input  wire logic [WIDTH-1:0] wr_data,
    output logic                  rd_valid,
    input  wire logic             rd_ready,
    output logic [WIDTH-1:0]      rd_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wp;
    logic [AW-1:0]    rp;
    logic [AW:0]      cnt;
    logic [AW:0]      next_cnt;
    logic             push;
    logic             pop;

    // flags are registered so the ready port comes from a flop
    assign push     = wr_valid & wr_ready;
    assign pop      = rd_valid & rd_ready;
    assign next_cnt = cnt + (AW+1)'(push) - (AW+1)'(pop);
    assign rd_data  = mem[rp];

    // occupancy and flags
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            cnt      <= '0;
            wr_ready <= 1'b1;
            rd_valid <= 1'b0;
        end
        else
        begin
            cnt      <= next_cnt;
            wr_ready <= next_cnt != (AW+1)'(DEPTH);
            rd_valid <= next_cnt != '0;
        end
    end

    // pointers, depth must be a power of two
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            wp <= '0;
            rp <= '0;
        end
        else
        begin
            if (push)
                wp <= wp + 1'b1;
            if (pop)
                rp <= rp + 1'b1;
        end
    end

    // storage, no reset needed
    always_ff @(posedge mclk)
    begin
        if (push)
            mem[wp] <= wr_data;
    end
endmodule

module lvl_limiter #(
    parameter int ATK_BASE_CYC  = lvl_pkg::ATK_BASE_CYC,
    parameter int REL_BASE_CYC  = lvl_pkg::REL_BASE_CYC,
    parameter int HOLD_BASE_CYC = lvl_pkg::HOLD_BASE_CYC
) (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    output logic [15:0]      reg_rdata,
    input  wire logic        in_valid,
    output logic             in_ready,
    input  wire logic [15:0] in_data,
    output logic             out_valid,
    input  wire logic        out_ready,
    output logic [15:0]      out_data,
    input  wire logic        clip_detect,
    input  wire logic [4:0]  vbat_level,
    output logic             clip_detect_enable,
    output logic             gain_stage_zc,
    output logic [7:0]       gain_atten
);
    logic [15:0] cfg_gd;
    logic [15:0] cfg_tt;
    logic [15:0] cfg_em;
    logic [15:0] cfg_cs;
    logic [15:0] cfg_cd;
    lvl_pkg::lvl_state_t state;
    logic [31:0] step_cnt;
    logic [4:0]  ev_cnt;
    logic [7:0]  atten;
    logic [15:0] peak;
    logic        en_q;
    logic        clip_q;
    logic        prev_sign;
    logic        fifo_valid;
    logic        fifo_ready;
    logic [15:0] fifo_data;
    logic        en;
    logic        en_rise;
    logic [2:0]  mode;
    logic        clip_mode;
    logic [7:0]  up_atten;
    logic [7:0]  lo_raw;
    logic [7:0]  lo_atten;
    logic [4:0]  cap_steps;
    logic [31:0] atk_iv;
    logic [31:0] rel_iv;
    logic [31:0] hold_cyc;
    logic [15:0] target;
    logic [15:0] below_thr;
    logic        peak_low;
    logic        trig_lvl;
    logic        clip_ev;
    logic        tick;
    logic        do_down;
    logic        do_up;
    logic        atk_exit;
    logic        hold_trig;
    logic        rel_trig;
    logic        hold_quiet;
    logic        proc;
    logic        zc_hit;
    logic [15:0] gain_lin;
    logic signed [32:0] prod;
    logic [15:0] gained;
    logic [15:0] mag;

    // interval of 2^code base periods, minus one for a down-counter
    function automatic logic [31:0] step_interval(input logic [31:0] base,
                                                  input logic [3:0]  code,
                                                  input logic [3:0]  max_sh);
        logic [3:0] sh;
        sh = (code > max_sh) ? max_sh : code;
        return (base << sh) - 32'h1;
    endfunction

    // samples queue here so the gain stage can stall the source
    lvl_fifo #(.WIDTH(16), .DEPTH(8)) u_fifo (
        .mclk     (mclk),
        .rst      (rst),
        .wr_valid (in_valid),
        .wr_ready (in_ready),
        .wr_data  (in_data),
        .rd_valid (fifo_valid),
        .rd_ready (fifo_ready),
        .rd_data  (fifo_data)
    );

    // register writes
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            cfg_gd <= lvl_pkg::RST_REG;
            cfg_tt <= lvl_pkg::RST_REG;
            cfg_em <= lvl_pkg::RST_REG;
            cfg_cs <= lvl_pkg::RST_REG;
            cfg_cd <= lvl_pkg::RST_REG;
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                lvl_pkg::ADDR_GAIN_DETECT: cfg_gd <= reg_wdata;
                lvl_pkg::ADDR_TIMING:      cfg_tt <= reg_wdata;
                lvl_pkg::ADDR_ENABLE_MODE: cfg_em <= reg_wdata;
                lvl_pkg::ADDR_CLIP_STEP:   cfg_cs <= reg_wdata;
                lvl_pkg::ADDR_CLIP_DET:    cfg_cd <= reg_wdata;
                default:                   ;
            endcase
        end
    end

    // register reads, unmapped addresses read zero
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            reg_rdata <= 16'h0000;
        else if (reg_rd)
        begin
            case (reg_addr)
                lvl_pkg::ADDR_GAIN_DETECT: reg_rdata <= cfg_gd;
                lvl_pkg::ADDR_TIMING:      reg_rdata <= cfg_tt;
                lvl_pkg::ADDR_ENABLE_MODE: reg_rdata <= cfg_em;
                lvl_pkg::ADDR_CLIP_STEP:   reg_rdata <= cfg_cs;
                lvl_pkg::ADDR_CLIP_DET:    reg_rdata <= cfg_cd;
                lvl_pkg::ADDR_STATUS:      reg_rdata <= {6'h00, 2'(state), gain_atten};
                default:                   reg_rdata <= 16'h0000;
            endcase
        end
    end

    // field decode and limits
    always_comb
    begin
        en        = cfg_em[lvl_pkg::EN_BIT];
        mode      = cfg_em[lvl_pkg::MODE_HI:lvl_pkg::MODE_LO];
        clip_mode = (mode == lvl_pkg::MODE_CLIP) || (mode == lvl_pkg::MODE_LOWBAT_CLIP);
        en_rise   = en & ~en_q;
        // limit window, 1.5 dB per upper code
        up_atten  = {2'b00, ~cfg_gd[lvl_pkg::UP_HI:lvl_pkg::UP_LO], 3'b000};
        lo_raw    = {1'b0, ~cfg_gd[lvl_pkg::LO_HI:lvl_pkg::LO_LO], 4'h0} + lvl_pkg::LO_ATTEN_BASE;
        if (clip_mode && lo_raw > lvl_pkg::CLIP_ATTEN_FLOOR)
            lo_raw = lvl_pkg::CLIP_ATTEN_FLOOR;
        lo_atten  = (lo_raw < up_atten) ? up_atten : lo_raw;
        // cap in 0.25 dB codes as steps
        cap_steps = 5'(({2'b00, cfg_cs[lvl_pkg::CAP_HI:lvl_pkg::CAP_LO]} << 2) / 5'h03);
        atk_iv    = step_interval(32'(ATK_BASE_CYC), cfg_tt[lvl_pkg::ATK_HI:lvl_pkg::ATK_LO],
                                  lvl_pkg::ATK_MAX_SHIFT);
        rel_iv    = step_interval(32'(REL_BASE_CYC), cfg_tt[lvl_pkg::REL_HI:lvl_pkg::REL_LO],
                                  lvl_pkg::REL_MAX_SHIFT);
        // hold length, code zero means none
        hold_cyc  = 32'h0;
        if (cfg_tt[lvl_pkg::HOLD_HI:lvl_pkg::HOLD_LO] != 4'h0)
            hold_cyc = step_interval(32'(HOLD_BASE_CYC),
                                     cfg_tt[lvl_pkg::HOLD_HI:lvl_pkg::HOLD_LO] - 4'h1,
                                     lvl_pkg::HOLD_MAX_SHIFT);
        // target in eighths of full scale
        target    = {1'b0, cfg_tt[lvl_pkg::TGT_HI:lvl_pkg::TGT_LO], 12'h000} + 16'h1000;
        below_thr = target - (target >> 3) - (target >> 5);
        peak_low  = peak < below_thr;
    end

    // triggers per mode, other mode codes never trigger
    always_comb
    begin
        case (mode)
            lvl_pkg::MODE_CLIP:
            begin
                trig_lvl = clip_detect;
                clip_ev  = clip_detect & ~clip_q;
            end
            lvl_pkg::MODE_LOWBAT_CLIP:
            begin
                trig_lvl = clip_detect & (vbat_level < cfg_em[lvl_pkg::VBAT_HI:lvl_pkg::VBAT_LO]);
                clip_ev  = trig_lvl & ~clip_q;
            end
            lvl_pkg::MODE_NORMAL:
            begin
                trig_lvl = peak > target;
                clip_ev  = 1'b0;
            end
            default:
            begin
                trig_lvl = 1'b0;
                clip_ev  = 1'b0;
            end
        endcase
    end

    // step decisions
    always_comb
    begin
        tick       = step_cnt == 32'h0;
        // no step once the exit condition holds
        do_down    = en && !en_rise && state == lvl_pkg::st_attack && tick
                     && !(clip_mode && ev_cnt >= cap_steps)
                     && !(clip_mode ? !trig_lvl : peak_low);
        do_up      = en && !en_rise && state == lvl_pkg::st_release && tick && !trig_lvl
                     && atten > up_atten;
        atk_exit   = state == lvl_pkg::st_attack && tick
                     && ((clip_mode && ev_cnt >= cap_steps)
                         || (clip_mode ? !trig_lvl : peak_low));
        hold_trig  = state == lvl_pkg::st_hold && (clip_mode ? clip_ev : trig_lvl);
        rel_trig   = state == lvl_pkg::st_release && trig_lvl;
        // quiet means no clip and low peak
        hold_quiet = peak_low && !(clip_mode && clip_detect);
    end

    // control state machine
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            state    <= lvl_pkg::st_idle;
            step_cnt <= 32'h0;
        end
        else if (!en)
        begin
            state    <= lvl_pkg::st_idle;
            step_cnt <= 32'h0;
        end
        else if (en_rise)
        begin
            state    <= lvl_pkg::st_release;
            step_cnt <= rel_iv;
        end
        else
        begin
            case (state)
                lvl_pkg::st_attack:
                begin
                    if (atk_exit)
                    begin
                        state    <= lvl_pkg::st_hold;
                        step_cnt <= hold_cyc;
                    end
                    else if (tick)
                        step_cnt <= atk_iv;
                    else
                        step_cnt <= step_cnt - 32'h1;
                end
                lvl_pkg::st_hold:
                begin
                    if (hold_trig)
                    begin
                        state    <= lvl_pkg::st_attack;
                        step_cnt <= 32'h0;
                    end
                    else if (!hold_quiet)
                        step_cnt <= hold_cyc;
                    else if (tick)
                    begin
                        state    <= lvl_pkg::st_release;
                        step_cnt <= rel_iv;
                    end
                    else
                        step_cnt <= step_cnt - 32'h1;
                end
                lvl_pkg::st_release:
                begin
                    if (rel_trig)
                    begin
                        state    <= lvl_pkg::st_attack;
                        step_cnt <= 32'h0;
                    end
                    else if (tick)
                        step_cnt <= rel_iv;
                    else
                        step_cnt <= step_cnt - 32'h1;
                end
                default:
                begin
                    state    <= lvl_pkg::st_release;
                    step_cnt <= rel_iv;
                end
            endcase
        end
    end

    // steps taken in the current clip event
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            ev_cnt <= 5'h00;
        // new event grants a fresh cap
        else if (!en || hold_trig || rel_trig || (clip_ev && state == lvl_pkg::st_attack))
            ev_cnt <= 5'h00;
        else if (do_down)
            ev_cnt <= ev_cnt + 5'h01;
    end

    // requested attenuation
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            atten <= 8'h00;
        else if (!en)
            atten <= 8'h00;
        else if (en_rise)
            atten <= up_atten;
        else if (do_down)
            atten <= (atten >= lo_atten) ? lo_atten : atten + 8'h01;
        else if (do_up)
            atten <= atten - 8'h01;
        else if (atten < up_atten)
            atten <= up_atten;
        else if (atten > lo_atten)
            atten <= lo_atten;
    end

    // gain stage, applied gain comes from the table then whole octaves
    assign gain_lin   = lvl_pkg::GAIN_TBL[gain_atten[4:0]] >> gain_atten[7:5];
    assign prod       = $signed({fifo_data[15], fifo_data}) * $signed({17'h00000, gain_lin});
    assign gained     = prod[30:15];
    assign fifo_ready = ~out_valid | out_ready;
    assign proc       = fifo_valid & fifo_ready;
    assign mag        = gained[15] ? 16'(-gained) : gained;
    assign zc_hit     = proc && (fifo_data == 16'h0000 || fifo_data[15] != prev_sign);

    // output register
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            out_valid <= 1'b0;
            out_data  <= 16'h0000;
        end
        else if (proc)
        begin
            out_valid <= 1'b1;
            out_data  <= gained;
        end
        else if (out_ready)
            out_valid <= 1'b0;
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            peak <= 16'h0000;
        else if (!en)
            peak <= 16'h0000;
        else if (proc)
        begin
            if (!cfg_gd[lvl_pkg::PK_BIT])
                peak <= mag;
            else if (mag >= peak)
                peak <= mag;
            else
                peak <= peak - (peak >> lvl_pkg::PEAK_DECAY_SH);
        end
    end

    // applied gain, zero-cross deferral trades response for fewer clicks
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            gain_atten <= 8'h00;
        else if (!en)
            gain_atten <= 8'h00;
        else if (en_rise)
            gain_atten <= up_atten;
        else if (!cfg_gd[lvl_pkg::ZC_BIT] || zc_hit)
            gain_atten <= atten;
    end

    // edge history and pin outputs
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            en_q               <= 1'b0;
            clip_q             <= 1'b0;
            prev_sign          <= 1'b0;
            gain_stage_zc      <= 1'b0;
            clip_detect_enable <= 1'b0;
        end
        else
        begin
            en_q   <= en;
            clip_q <= (mode == lvl_pkg::MODE_LOWBAT_CLIP) ? trig_lvl : clip_detect;
            if (proc)
                prev_sign <= fifo_data[15];
            gain_stage_zc      <= cfg_cs[lvl_pkg::GSZC_BIT] | cfg_gd[lvl_pkg::ZC_BIT];
            clip_detect_enable <= cfg_cd[lvl_pkg::CLIPDET_BIT];
        end
    end
endmodule

// file: dv/lvl_limiter_asserts.sv
// port checker for the level limiter
// assumes bind onto lvl_limiter; tracks enable and upper limit from writes
`timescale 1ns/100ps
module lvl_limiter_asserts (
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        reg_wr,
    input wire logic [7:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        out_valid,
    input wire logic        out_ready,
    input wire logic [15:0] out_data,
    input wire logic        gain_stage_zc,
    input wire logic [7:0]  gain_atten
);
    logic       en_q;
    logic [2:0] up_q;
    logic [7:0] up_att;
    logic [2:0] lo_q;
    logic [7:0] lo_att;
    logic       wr_en;
    assign up_att = {2'b00, 3'h7 - up_q, 3'h0};
    assign lo_att = {1'b0, 3'h7 - lo_q, 4'h0} + 8'h20;
    assign wr_en  = reg_wr && reg_addr == 8'h2e;
    // shadow copies, so limits are known without peeking inside
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            en_q <= 1'b0;
            up_q <= 3'h0;
            lo_q <= 3'h0;
        end
        else
        begin
            if (wr_en)
                en_q <= reg_wdata[15];
            if (reg_wr && reg_addr == 8'h2c)
                up_q <= reg_wdata[7:5];
            if (reg_wr && reg_addr == 8'h2c)
                lo_q <= reg_wdata[3:1];
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    AST_UNITY: assert property (!en_q && !$past(en_q) |-> gain_atten == 8'h00)
        else $error("gain applied while disabled");
    AST_LOAD_MAX: assert property (wr_en && reg_wdata[15] && !en_q
        |-> ##[1:2] gain_atten == up_att) else $error("enable did not load upper gain");
    AST_UPPER: assert property (en_q && $past(en_q, 2) |-> gain_atten >= up_att)
        else $error("gain above upper limit");
    AST_FLOOR: assert property (en_q && $past(en_q, 2) |-> gain_atten <= 8'haa
        && (gain_atten <= lo_att || gain_atten == up_att))
        else $error("attenuation beyond floor");
    AST_ONE_STEP: assert property (en_q && $past(en_q, 2) && $changed(gain_atten)
        |-> gain_atten - $past(gain_atten) == 8'h01 || $past(gain_atten) - gain_atten == 8'h01)
        else $error("gain step not one unit");
    AST_NO_DIRECT_RELEASE: assert property (en_q && $past(en_q, 2)
        && gain_atten < $past(gain_atten) |-> $past(gain_atten) <= $past(gain_atten, 2))
        else $error("release right after attack step");
    AST_ZC_FORCE: assert property (reg_wr && reg_addr == 8'h2c && reg_wdata[14]
        |-> ##[1:2] gain_stage_zc) else $error("gain stage zero cross not forced");
    AST_OUT_HOLD: assert property (out_valid && !out_ready
        |=> out_valid && $stable(out_data)) else $error("output dropped while stalled");
endmodule
bind lvl_limiter lvl_limiter_asserts u_asserts (.mclk, .rst, .reg_wr, .reg_addr, .reg_wdata,
    .out_valid, .out_ready, .out_data, .gain_stage_zc, .gain_atten);

// file: dv/lvl_partner.sv
// far side model: sample source, clip detector and sample sink
// assumes the bench sets amplitude, clip and stall levels off the rising edge
`timescale 1ns/100ps
module lvl_partner (
    input  wire logic        mclk,
    input  wire logic [15:0] amp,
    input  wire logic        clip_req,
    input  wire logic        stall,
    input  wire logic        in_ready,
    input  wire logic        clip_detect_enable,
    output logic             in_valid,
    output logic [15:0]      in_data,
    output logic             clip_detect,
    output logic             out_ready
);
    logic        taken = 1'b0;
    logic        neg   = 1'b0;
    logic [15:0] cur   = 16'h0000;
    assign in_valid    = 1'b1;
    assign in_data     = neg ? -cur : cur;
    // detector silent unless the host enabled it
    assign clip_detect = clip_req && clip_detect_enable;
    assign out_ready   = !stall;
    always @(posedge mclk)
        taken <= in_valid && in_ready;
    // next sample only once taken; sign flips give zero crossings
    always @(negedge mclk)
    begin
        if (taken)
        begin
            neg <= !neg;
            cur <= amp;
        end
    end
endmodule

// file: dv/lvl_limiter_tb.sv
// self-checking bench: register tasks, fifo stall, normal, clip, low battery
// assumes shortened timing parameters so the run stays brief
`timescale 1ns/100ps
module lvl_limiter_tb;
    logic        mclk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic        clip_req = 1'b0, stall = 1'b0, in_valid, in_ready, out_valid, out_ready;
    logic        clip_detect, clip_detect_enable, gain_stage_zc;
    logic [7:0]  reg_addr = 8'h00, gain_atten;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata, in_data, out_data, amp = 16'h07d0;
    logic [4:0]  vbat_level = 5'h05;
    int          error_cnt = 0, comparisons = 0, cycles = 0;
    always #2 mclk = ~mclk;
    lvl_limiter #(.ATK_BASE_CYC(4), .REL_BASE_CYC(16), .HOLD_BASE_CYC(16)) dut (.mclk, .rst,
        .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .in_valid, .in_ready, .in_data,
        .out_valid, .out_ready, .out_data, .clip_detect, .vbat_level, .clip_detect_enable,
        .gain_stage_zc, .gain_atten);
    lvl_partner u_far (.mclk, .amp, .clip_req, .stall, .in_ready, .clip_detect_enable,
        .in_valid, .in_data, .clip_detect, .out_ready);
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge mclk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge mclk);
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(negedge mclk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge mclk);
        reg_rd = 1'b0;
        check(reg_rdata, exp);
    endtask
    task automatic atten_is(input logic [7:0] exp);
        check({8'h00, gain_atten}, {8'h00, exp});
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // hang guard, well above the few thousand cycles the tests need
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            error_cnt++;
            end_of_test();
        end
    end
    initial
    begin
        cyc(10);
        rst = 1'b0;
        rd(8'h2c, 16'h0000);
        rd(8'h2e, 16'h0000);
        rd(8'h00, 16'h0000);
        $display("test reset done");
        wr(8'h2c, 16'h40a2);
        wr(8'h2d, 16'h0006);
        wr(8'h2f, 16'h0c00);
        wr(8'h69, 16'h0010);
        rd(8'h2c, 16'h40a2);
        check({15'h0, gain_stage_zc}, 16'h0001);
        check({15'h0, clip_detect_enable}, 16'h0001);
        stall = 1'b1;
        cyc(20);
        check({15'h0, in_ready}, 16'h0000);
        stall = 1'b0;
        cyc(20);
        check({15'h0, in_ready}, 16'h0001);
        check(out_data[15] ? 16'(-out_data) : out_data, 16'h07d0);
        $display("test setup and fifo done");
        wr(8'h2e, 16'ha000);
        cyc(3);
        atten_is(8'h10);
        rd(8'h30, 16'h0310);
        amp = 16'h7530;
        cyc(400);
        check({15'h0, gain_atten > 8'h10 && gain_atten <= 8'h80}, 16'h0001);
        amp = 16'h03e8;
        cyc(1500);
        atten_is(8'h10);
        wr(8'h2e, 16'h0000);
        cyc(3);
        atten_is(8'h00);
        $display("test normal mode done");
        wr(8'h2e, 16'h8000);
        cyc(3);
        atten_is(8'h10);
        clip_req = 1'b1;
        cyc(100);
        atten_is(8'h14);
        clip_req = 1'b0;
        cyc(1);
        clip_req = 1'b1;
        cyc(100);
        atten_is(8'h18);
        clip_req = 1'b0;
        cyc(400);
        atten_is(8'h10);
        $display("test clip mode done");
        wr(8'h2e, 16'h9080);
        clip_req = 1'b1;
        cyc(100);
        atten_is(8'h10);
        vbat_level = 5'h03;
        cyc(100);
        atten_is(8'h14);
        clip_req = 1'b0;
        $display("test low battery mode done");
        end_of_test();
    end
endmodule
